// ### design/conv_timer.sv
`timescale 1ns/1ps
module conv_timer #(
   parameter int unsigned CONV_CYC = 32'(temp_alarm_pkg::CONV_CYC_DEF),
   parameter int unsigned SLOW_CYC = 32'(temp_alarm_pkg::SLOW_CYC_DEF)
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control
   input wire logic [3:0] rateCode,
   input wire logic standby,
   input wire logic oneShot,
   // Conversion status
   output logic convStart,
   output logic convEnd,
   output logic busy
);

   logic [31:0] convCnt_q;
   logic [31:0] gapCnt_q;
   logic busy_q;
   logic [3:0] shiftAmt;
   logic [31:0] periodCyc;
   logic autoDue;

   // Interval halves per code step; codes above the fastest stay fastest
   assign shiftAmt = (rateCode > temp_alarm_pkg::RATE_FAST_CODE) ?
                     temp_alarm_pkg::RATE_FAST_CODE : rateCode;
   assign periodCyc = SLOW_CYC >> shiftAmt;
   assign autoDue = !standby && (gapCnt_q >= periodCyc - 32'd1);
   // A start request while converting is dropped
   assign convStart = !busy_q && (oneShot || autoDue);
   assign convEnd = busy_q && (convCnt_q == CONV_CYC - 32'd1);
   assign busy = busy_q;

   // Busy flag; a conversion runs from power-on
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b1;
      end else if (convStart) begin
         busy_q <= 1'b1;
      end else if (convEnd) begin
         busy_q <= 1'b0;
      end
   end

   // Conversion length counter
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         convCnt_q <= 32'd0;
      end else if (!busy_q || convEnd) begin
         convCnt_q <= 32'd0;
      end else begin
         convCnt_q <= convCnt_q + 32'd1;
      end
   end

   // Rate timer, restarted by every start so a one-shot gives a full gap
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gapCnt_q <= 32'd0;
      end else if (convStart) begin
         gapCnt_q <= 32'd0;
      end else if (gapCnt_q != 32'hffff_ffff) begin
         gapCnt_q <= gapCnt_q + 32'd1;
      end
   end

endmodule

// ### design/temp_alarm_pkg.sv
package temp_alarm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam longint unsigned CLK_HZ = 64'd50_000_000;
   localparam longint unsigned CONV_TIME_MS = 64'd125;
   localparam longint unsigned CONV_CYC_DEF = (CONV_TIME_MS * CLK_HZ) / 64'd1000;
   localparam longint unsigned SLOW_PERIOD_S = 64'd16;
   localparam longint unsigned SLOW_CYC_DEF = SLOW_PERIOD_S * CLK_HZ;
   localparam logic [3:0] RATE_FAST_CODE = 4'h8;
   localparam logic [3:0] RATE_EXT_MAX = 4'h6;

   ////////////////////////////////////////////////////////////////////////////
   // Command byte map
   localparam logic [7:0] CMD_LOCAL_TEMP = 8'h00;
   localparam logic [7:0] CMD_REMOTE_TEMP = 8'h01;
   localparam logic [7:0] CMD_FLAGS_RD = 8'h02;
   localparam logic [7:0] CMD_CFG_RD = 8'h03;
   localparam logic [7:0] CMD_RATE_RD = 8'h04;
   localparam logic [7:0] CMD_LHIGH_RD = 8'h05;
   localparam logic [7:0] CMD_LLOW_RD = 8'h06;
   localparam logic [7:0] CMD_RHIGH_RD = 8'h07;
   localparam logic [7:0] CMD_RLOW_RD = 8'h08;
   localparam logic [7:0] CMD_CFG_WR = 8'h09;
   localparam logic [7:0] CMD_RATE_WR = 8'h0a;
   localparam logic [7:0] CMD_LHIGH_WR = 8'h0b;
   localparam logic [7:0] CMD_LLOW_WR = 8'h0c;
   localparam logic [7:0] CMD_RHIGH_WR = 8'h0d;
   localparam logic [7:0] CMD_RLOW_WR = 8'h0e;
   localparam logic [7:0] CMD_ONE_SHOT = 8'h0f;
   localparam logic [7:0] CMD_REMOTE_FRAC = 8'h10;
   localparam logic [7:0] CMD_LOCAL_FRAC = 8'h11;
   localparam logic [7:0] CMD_R_OT2 = 8'h16;
   localparam logic [7:0] CMD_L_OT2 = 8'h17;
   localparam logic [7:0] CMD_R_OT1 = 8'h19;
   localparam logic [7:0] CMD_L_OT1 = 8'h20;
   localparam logic [7:0] CMD_OVERTEMP_HYSTERESIS = 8'h21;
   localparam logic [7:0] CMD_MAKER = 8'hfe;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and codes
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h20;
   localparam logic [3:0] RATE_RST = 4'h8;
   localparam logic [7:0] HIGH_RST = 8'h46;
   localparam logic [7:0] LOW_RST = 8'hc9;
   localparam logic [7:0] OT_RST = 8'h55;
   localparam logic [7:0] OVERTEMP_HYSTERESIS_RST = 8'h0a;
   localparam logic [7:0] FAULT_CODE = 8'h80;
   localparam logic [7:0] UNMAPPED_RD = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CFG_MASK_BIT = 7;
   localparam int CFG_STBY_BIT = 6;
   localparam int CFG_JTYPE_BIT = 5;
   localparam logic [7:0] CFG_WR_MASK = 8'he0;

   // Overtemp comparator entries: local/remote stage 1, local/remote stage 2
   localparam int OT_N = 4;

   typedef struct packed {
      logic cmdValid;
      logic [7:0] cmdByte;
      logic wrValid;
      logic [7:0] wrData;
      logic rdReq;
      logic araDone;
      logic araWon;
   } host_req_t;

   typedef struct packed {
      logic [7:0] localInt;
      logic [2:0] localFrac;
      logic [7:0] remoteInt;
      logic [2:0] remoteFrac;
      logic openFault;
      logic shortFault;
   } adc_result_t;

   // Alarm conditions in status bit order 6..2
   typedef struct packed {
      logic localHigh;
      logic localLow;
      logic remoteHigh;
      logic remoteLow;
      logic openJct;
   } alarm_cond_t;

endpackage

// ### design/temp_sensor_alarm_regs.sv
`timescale 1ns/1ps
module temp_sensor_alarm_regs #(
   parameter int unsigned CONV_CYC = 32'(temp_alarm_pkg::CONV_CYC_DEF),
   parameter int unsigned SLOW_CYC = 32'(temp_alarm_pkg::SLOW_CYC_DEF),
   parameter logic [6:0] SLAVE_ADDR = 7'h4c,
   parameter logic [7:0] MAKER_ID = 8'h5a // Arbitrary value
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Byte-level requests from the serial front end
   input wire temp_alarm_pkg::host_req_t hostReq,
   output logic [7:0] rdData_q,
   output logic rdValid_q,
   // Alert response
   output logic araRespond,
   output logic [6:0] araAddr,
   // Converter side
   input wire temp_alarm_pkg::adc_result_t adcIn,
   output logic convStart,
   output logic busy,
   output logic junctionType,
   // Open-drain pins, pulled low while enabled
   output logic alertOe,
   output logic otStage1Oe,
   output logic otStage2Oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] ptr_q;
   logic [7:0] cfg_q;
   logic [3:0] rate_q;
   logic [7:0] localHigh_q, localLow_q, remoteHigh_q, remoteLow_q;
   logic [7:0] otLimit_q [temp_alarm_pkg::OT_N];
   logic [7:0] overtemp_hysteresis_q;
   logic [7:0] localTemp_q, remoteTemp_q;
   logic [2:0] localFrac_q, remoteFrac_q;
   logic [4:0] flags_q;
   logic [4:0] flags_d;
   logic alertLatch_q;
   logic [temp_alarm_pkg::OT_N-1:0] ot_q;
   logic [7:0] otTemp [temp_alarm_pkg::OT_N];
   logic [7:0] remoteNew;
   temp_alarm_pkg::alarm_cond_t condNow;
   temp_alarm_pkg::alarm_cond_t cond_q;
   logic convEnd;
   logic oneShot;
   logic statusRead;
   logic araClear;
   logic wrHit;
   logic alertMasked;
   logic [7:0] rdMux;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion scheduling
   assign oneShot = (hostReq.cmdValid && hostReq.cmdByte == temp_alarm_pkg::CMD_ONE_SHOT) ||
                    (wrHit && ptr_q == temp_alarm_pkg::CMD_ONE_SHOT);

   conv_timer #(
      .CONV_CYC(CONV_CYC),
      .SLOW_CYC(SLOW_CYC)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .rateCode(rate_q),
      .standby(cfg_q[temp_alarm_pkg::CFG_STBY_BIT]),
      .oneShot(oneShot),
      .convStart(convStart),
      .convEnd(convEnd),
      .busy(busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Command pointer and register writes
   assign wrHit = hostReq.wrValid;
   assign statusRead = hostReq.rdReq && ptr_q == temp_alarm_pkg::CMD_FLAGS_RD;
   assign araClear = hostReq.araDone && hostReq.araWon;

   // Pointer is loaded by every command byte
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ptr_q <= temp_alarm_pkg::PTR_RST;
      end else if (hostReq.cmdValid) begin
         ptr_q <= hostReq.cmdByte;
      end
   end

   // Configuration and rate
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_q <= temp_alarm_pkg::CFG_RST;
         rate_q <= temp_alarm_pkg::RATE_RST;
      end else if (wrHit) begin
         if (ptr_q == temp_alarm_pkg::CMD_CFG_WR) begin
            cfg_q <= hostReq.wrData & temp_alarm_pkg::CFG_WR_MASK;
         end
         if (ptr_q == temp_alarm_pkg::CMD_RATE_WR) begin
            rate_q <= hostReq.wrData[3:0];
         end
      end
   end

   // Alert limits
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         localHigh_q <= temp_alarm_pkg::HIGH_RST;
         remoteHigh_q <= temp_alarm_pkg::HIGH_RST;
         localLow_q <= temp_alarm_pkg::LOW_RST;
         remoteLow_q <= temp_alarm_pkg::LOW_RST;
      end else if (wrHit) begin
         unique case (ptr_q)
            temp_alarm_pkg::CMD_LHIGH_WR: localHigh_q <= hostReq.wrData;
            temp_alarm_pkg::CMD_LLOW_WR: localLow_q <= hostReq.wrData;
            temp_alarm_pkg::CMD_RHIGH_WR: remoteHigh_q <= hostReq.wrData;
            temp_alarm_pkg::CMD_RLOW_WR: remoteLow_q <= hostReq.wrData;
            default: ;
         endcase
      end
   end

   // Overtemp thresholds and shared hysteresis
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < temp_alarm_pkg::OT_N; i++) begin
            otLimit_q[i] <= temp_alarm_pkg::OT_RST;
         end
         overtemp_hysteresis_q <= temp_alarm_pkg::OVERTEMP_HYSTERESIS_RST;
      end else if (wrHit) begin
         unique case (ptr_q)
            temp_alarm_pkg::CMD_L_OT1: otLimit_q[0] <= hostReq.wrData;
            temp_alarm_pkg::CMD_R_OT1: otLimit_q[1] <= hostReq.wrData;
            temp_alarm_pkg::CMD_L_OT2: otLimit_q[2] <= hostReq.wrData;
            temp_alarm_pkg::CMD_R_OT2: otLimit_q[3] <= hostReq.wrData;
            temp_alarm_pkg::CMD_OVERTEMP_HYSTERESIS: overtemp_hysteresis_q <= hostReq.wrData;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Temperature results
   // A broken remote junction reports the fault code
   assign remoteNew = (adcIn.openFault || adcIn.shortFault) ?
                      temp_alarm_pkg::FAULT_CODE : adcIn.remoteInt;

   // Integer parts load at the end of each conversion
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         localTemp_q <= 8'h00;
         remoteTemp_q <= 8'h00;
      end else if (convEnd) begin
         localTemp_q <= adcIn.localInt;
         remoteTemp_q <= remoteNew;
      end
   end

   // Fractions only load when the rate leaves time for full resolution
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         localFrac_q <= 3'h0;
         remoteFrac_q <= 3'h0;
      end else if (convEnd && rate_q <= temp_alarm_pkg::RATE_EXT_MAX) begin
         localFrac_q <= adcIn.localFrac;
         remoteFrac_q <= (remoteNew == adcIn.remoteInt) ? adcIn.remoteFrac : 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alarm conditions from the fresh result
   always_comb begin
      condNow.localHigh = $signed(adcIn.localInt) >= $signed(localHigh_q);
      condNow.localLow = $signed(adcIn.localInt) < $signed(localLow_q);
      condNow.remoteHigh = $signed(remoteNew) >= $signed(remoteHigh_q);
      condNow.remoteLow = $signed(remoteNew) < $signed(remoteLow_q);
      condNow.openJct = adcIn.openFault;
   end

   // Conditions of the last conversion decide what a status read may clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cond_q <= '0;
      end else if (convEnd) begin
         cond_q <= condNow;
      end
   end

   // Sticky flags 6:2; a conversion end setting a flag beats a read clearing it
   always_comb begin
      flags_d = flags_q;
      if (statusRead) begin
         flags_d = flags_q & cond_q;
      end
      if (convEnd) begin
         flags_d = flags_d | condNow;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flags_q <= 5'h00;
      end else begin
         flags_q <= flags_d;
      end
   end

   // Alert latch sets only at a conversion end, so at most once per conversion
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alertLatch_q <= 1'b0;
      end else if (convEnd && (|condNow)) begin
         alertLatch_q <= 1'b1;
      end else if (statusRead || araClear) begin
         alertLatch_q <= 1'b0;
      end
   end

   assign alertMasked = alertLatch_q && !cfg_q[temp_alarm_pkg::CFG_MASK_BIT];
   assign alertOe = alertMasked;
   assign araRespond = alertMasked;
   assign araAddr = SLAVE_ADDR;
   assign junctionType = cfg_q[temp_alarm_pkg::CFG_JTYPE_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Overtemp comparators with hysteresis
   assign otTemp[0] = localTemp_q;
   assign otTemp[1] = remoteTemp_q;
   assign otTemp[2] = localTemp_q;
   assign otTemp[3] = remoteTemp_q;

   for (genvar g = 0; g < temp_alarm_pkg::OT_N; g++) begin : g_ot
      logic signed [8:0] relLevel;
      logic signed [8:0] tempExt;
      assign relLevel = $signed({otLimit_q[g][7], otLimit_q[g]}) -
                        $signed({overtemp_hysteresis_q[7], overtemp_hysteresis_q});
      assign tempExt = $signed({otTemp[g][7], otTemp[g]});
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            ot_q[g] <= 1'b0;
         end else if ($signed(otTemp[g]) >= $signed(otLimit_q[g])) begin
            ot_q[g] <= 1'b1;
         end else if (tempExt < relLevel) begin
            ot_q[g] <= 1'b0;
         end
      end
   end

   assign otStage1Oe = ot_q[0] || ot_q[1];
   assign otStage2Oe = ot_q[2] || ot_q[3];

   ////////////////////////////////////////////////////////////////////////////
   // Read path
   always_comb begin
      unique case (ptr_q)
         temp_alarm_pkg::CMD_LOCAL_TEMP: rdMux = localTemp_q;
         temp_alarm_pkg::CMD_REMOTE_TEMP: rdMux = remoteTemp_q;
         temp_alarm_pkg::CMD_FLAGS_RD: rdMux = {busy, flags_q, ot_q[1], ot_q[0]};
         temp_alarm_pkg::CMD_CFG_RD: rdMux = cfg_q;
         temp_alarm_pkg::CMD_RATE_RD: rdMux = {4'h0, rate_q};
         temp_alarm_pkg::CMD_LHIGH_RD: rdMux = localHigh_q;
         temp_alarm_pkg::CMD_LLOW_RD: rdMux = localLow_q;
         temp_alarm_pkg::CMD_RHIGH_RD: rdMux = remoteHigh_q;
         temp_alarm_pkg::CMD_RLOW_RD: rdMux = remoteLow_q;
         temp_alarm_pkg::CMD_REMOTE_FRAC: rdMux = {remoteFrac_q, 5'h00};
         temp_alarm_pkg::CMD_LOCAL_FRAC: rdMux = {localFrac_q, 5'h00};
         temp_alarm_pkg::CMD_R_OT2: rdMux = otLimit_q[3];
         temp_alarm_pkg::CMD_L_OT2: rdMux = otLimit_q[2];
         temp_alarm_pkg::CMD_R_OT1: rdMux = otLimit_q[1];
         temp_alarm_pkg::CMD_L_OT1: rdMux = otLimit_q[0];
         temp_alarm_pkg::CMD_OVERTEMP_HYSTERESIS: rdMux = overtemp_hysteresis_q;
         temp_alarm_pkg::CMD_MAKER: rdMux = MAKER_ID;
         default: rdMux = temp_alarm_pkg::UNMAPPED_RD;
      endcase
   end

   // Read data registered, valid one cycle after the request
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdData_q <= 8'h00;
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= hostReq.rdReq;
         if (hostReq.rdReq) begin
            rdData_q <= rdMux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_statusRead;
      hostReq.rdReq && ptr_q == temp_alarm_pkg::CMD_FLAGS_RD && !convEnd;
   endsequence

   sequence s_araWin;
      hostReq.araDone && hostReq.araWon && !convEnd;
   endsequence

   property p_alertOncePerConv;
      $rose(alertLatch_q) |-> $past(convEnd);
   endproperty
   a_alertOncePerConv: assert property (p_alertOncePerConv)
      else $error("Alert latch rose without a conversion end");

   property p_alertHeld;
      alertLatch_q && !hostReq.rdReq && !hostReq.araDone |=> alertLatch_q;
   endproperty
   a_alertHeld: assert property (p_alertHeld)
      else $error("Alert latch dropped without a clearing event");

   property p_araClears;
      s_araWin |=> !alertLatch_q;
   endproperty
   a_araClears: assert property (p_araClears)
      else $error("Won alert response did not clear latch");

   property p_araLoseKeeps;
      hostReq.araDone && !hostReq.araWon && alertLatch_q && !hostReq.rdReq |=> alertLatch_q;
   endproperty
   a_araLoseKeeps: assert property (p_araLoseKeeps)
      else $error("Lost arbitration cleared the alert");

   property p_statusClear;
      s_statusRead |=> flags_q == $past(flags_q & cond_q);
   endproperty
   a_statusClear: assert property (p_statusClear)
      else $error("Status read cleared flags wrongly");

   property p_otSet;
      $signed(otTemp[0]) >= $signed(otLimit_q[0]) |=> ot_q[0] && otStage1Oe;
   endproperty
   a_otSet: assert property (p_otSet)
      else $error("Stage one output missed threshold");

   property p_faultCode;
      convEnd && (adcIn.openFault || adcIn.shortFault) |=> remoteTemp_q == temp_alarm_pkg::FAULT_CODE;
   endproperty
   a_faultCode: assert property (p_faultCode)
      else $error("Remote fault code not loaded");

   property p_shotDiscard;
      busy && !convEnd && oneShot |=> u_timer.convCnt_q == $past(u_timer.convCnt_q) + 32'd1;
   endproperty
   a_shotDiscard: assert property (p_shotDiscard)
      else $error("Conversion started while busy");

   property p_cfgReserved;
      hostReq.rdReq && ptr_q == temp_alarm_pkg::CMD_CFG_RD |=> rdValid_q && rdData_q[4:0] == 5'h00;
   endproperty
   a_cfgReserved: assert property (p_cfgReserved)
      else $error("Reserved config bits read nonzero");

endmodule

// ### tb/host_model.sv
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic sys_clk,
   // Byte requests and answers
   output temp_alarm_pkg::host_req_t hostReq,
   input wire logic [7:0] rdData_q,
   input wire logic rdValid_q,
   input wire logic araRespond
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle request lines
   initial hostReq = '0;
   // One request pulse; released data lines flip so stale bytes never look valid
   task automatic send(input logic [4:0] k, input logic [7:0] b);
      @(negedge sys_clk);
      hostReq = '{k[4], b, k[3], b, k[2], k[1], k[0]};
      @(negedge sys_clk);
      hostReq = '{1'b0, ~b, 1'b0, ~b, 1'b0, 1'b0, 1'b0};
   endtask
   // Command byte alone (pointer set or Send Byte)
   task automatic cmd(input logic [7:0] b);
      send(5'h10, b);
   endtask
   // Receive Byte at the current pointer, answer taken while rdValid_q stands
   task automatic rd(output logic [7:0] d, output logic v);
      send(5'h04, 8'h00);
      d = rdData_q;
      v = rdValid_q;
   endtask
   // Alert response, issued only while an alert is pending
   task automatic ara(input logic won);
      if (araRespond === 1'b1) send({4'h1, won}, 8'h00);
   endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   ////////////////////////////////////////////////////////////////////////////
   // Signals and model state
   logic sys_clk;
   logic rst;
   temp_alarm_pkg::host_req_t hostReq;
   temp_alarm_pkg::adc_result_t adcIn;
   logic [7:0] rdData_q, d;
   logic [6:0] araAddr;
   logic [2:0] fr;
   logic rdValid_q, araRespond, convStart, busy, junctionType, v;
   logic alertOe, otStage1Oe, otStage2Oe;
   int bad_count, n_compared, nStarts, s0;
   logic [7:0] m [int];

   temp_sensor_alarm_regs #(.CONV_CYC(32'h32), .SLOW_CYC(32'h800)) DUT (
      .sys_clk(sys_clk), .rst(rst), .hostReq(hostReq), .rdData_q(rdData_q),
      .rdValid_q(rdValid_q), .araRespond(araRespond), .araAddr(araAddr), .adcIn(adcIn),
      .convStart(convStart), .busy(busy), .junctionType(junctionType), .alertOe(alertOe),
      .otStage1Oe(otStage1Oe), .otStage2Oe(otStage2Oe));
   host_model HOST (.sys_clk(sys_clk), .hostReq(hostReq), .rdData_q(rdData_q),
      .rdValid_q(rdValid_q), .araRespond(araRespond));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and start counter
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (convStart === 1'b1) nStarts++;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Read one register; codes absent from the model read ffh
   task automatic rchk(input logic [7:0] a);
      HOST.cmd(a);
      HOST.rd(d, v);
      chk({7'h00, v}, 8'h01);
      chk(d, m.exists(a) ? m[a] : 8'hff);
   endtask
   // Write one register and track it in the model
   task automatic wreg(input logic [7:0] a, input logic [7:0] b);
      HOST.cmd(a);
      HOST.send(5'h08, b);
      if (a == 8'h09) m[3] = b & 8'he0;
      else if (a == 8'h0a) m[4] = {4'h0, b[3:0]};
      else m[a] = b;
   endtask
   // Wait for idle converter under a bound, then let outputs settle
   task automatic idle();
      for (int k = 0; busy !== 1'b0; k++) begin
         if (k > 500) begin
            bad_count++;
            tally_and_finish();
         end
         @(negedge sys_clk);
      end
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic shot();
      idle();
      HOST.cmd(8'h0f);
      idle();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog: the whole run needs under a thousand cycles
   initial begin
      #(20 * 20000);
      bad_count++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      m = '{8'h02: 8'h80, 8'h03: 8'h20, 8'h04: 8'h08, 8'h05: 8'h46, 8'h06: 8'hc9,
         8'h07: 8'h46, 8'h08: 8'hc9, 8'h16: 8'h55, 8'h17: 8'h55, 8'h19: 8'h55,
         8'h20: 8'h55, 8'h21: 8'h0a};
      adcIn = '{8'h19, 3'h0, 8'h19, 3'h0, 1'b0, 1'b0};
      rst = 1'b1;
      void'($urandom(32'h44f7));
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      HOST.rd(d, v);
      chk(d, 8'h00);
      foreach (m[a]) rchk(a[7:0]);
      rchk(8'h30);
      rchk(8'h0b);
      // Config fields, standby entered
      wreg(8'h09, 8'hff);
      rchk(8'h03);
      chk({7'h00, junctionType}, 8'h01);
      wreg(8'h09, 8'h40);
      chk({7'h00, junctionType}, 8'h00);
      wreg(8'h0a, 8'($urandom));
      rchk(8'h04);
      wreg(8'h0a, 8'h06);
      // High limit reached exactly, fraction readable at slow rate
      fr = 3'($urandom);
      adcIn.localInt = 8'h46;
      adcIn.localFrac = fr;
      adcIn.remoteInt = {2'b00, 6'($urandom)};
      adcIn.remoteFrac = 3'($urandom);
      shot();
      chk({alertOe, araRespond, araAddr[5:0]}, 8'hcc);
      m[0] = 8'h46;
      m[8'h11] = {fr, 5'h00};
      rchk(8'h11);
      m[1] = adcIn.remoteInt;
      m[8'h10] = {adcIn.remoteFrac, 5'h00};
      rchk(8'h01);
      rchk(8'h10);
      rchk(8'h00);
      // Lost and won alert responses, standby holds afterwards
      HOST.ara(1'b0);
      chk({7'h00, alertOe}, 8'h01);
      HOST.ara(1'b1);
      s0 = nStarts;
      repeat (20) @(negedge sys_clk);
      chk({alertOe, 7'(nStarts - s0)}, 8'h00);
      shot();
      chk({7'h00, alertOe}, 8'h01);
      m[2] = 8'h40;
      rchk(8'h02);
      chk({7'h00, alertOe}, 8'h00);
      rchk(8'h02);
      // Mask gates the pin, latch still sets
      wreg(8'h09, 8'hc0);
      shot();
      chk({alertOe, araRespond, 6'h00}, 8'h00);
      wreg(8'h09, 8'h40);
      chk({7'h00, alertOe}, 8'h01);
      adcIn.localInt = 8'h19;
      shot();
      rchk(8'h02);
      m[2] = 8'h00;
      rchk(8'h02);
      // Local stage two limit moved down to +80
      wreg(8'h17, 8'h50);
      rchk(8'h17);
      // Overtemperature set, hysteresis band, release
      adcIn.localInt = 8'h55;
      shot();
      chk({otStage1Oe, otStage2Oe, 6'h00}, 8'hc0);
      m[2] = 8'h41;
      rchk(8'h02);
      adcIn.localInt = 8'h4b;
      shot();
      rchk(8'h02);
      chk({otStage1Oe, otStage2Oe, 6'h00}, 8'hc0);
      adcIn.localInt = 8'h4a;
      shot();
      chk({otStage1Oe, otStage2Oe, 6'h00}, 8'h40);
      // Shorted, then open remote junction
      adcIn.shortFault = 1'b1;
      shot();
      m[1] = 8'h80;
      rchk(8'h01);
      adcIn.openFault = 1'b1;
      shot();
      m[2] = 8'h4c;
      rchk(8'h02);
      // Second one-shot while busy is dropped
      s0 = nStarts;
      HOST.cmd(8'h0f);
      HOST.cmd(8'h0f);
      idle();
      chk(8'(nStarts - s0), 8'h01);
      tally_and_finish();
   end
endmodule
